// [pkg/gpio_ef_pkg.sv]
/*
  Constants for the port E upper / port F pin logic: register byte
  offsets, field positions, reset values and the sync depth.
  Assumes an APB slave with 32-bit data, one register per word.
*/
package gpio_ef_pkg;
  localparam logic [7:0] OFF_PORT_E_PIN_LEVELS   = 8'h00;
  localparam logic [7:0] OFF_PORT_E_OUTPUT_LATCH = 8'h04;
  localparam logic [7:0] OFF_PORT_E_DIRECTION    = 8'h08;
  localparam logic [7:0] OFF_PAD_CONFIGURATION   = 8'h0C;
  localparam logic [7:0] OFF_ANALOG_SELECT_LOW   = 8'h10;
  localparam logic [7:0] OFF_PORT_F_PIN_LEVELS   = 8'h14;
  localparam logic [7:0] OFF_PORT_F_OUTPUT_LATCH = 8'h18;
  localparam logic [7:0] OFF_PORT_F_DIRECTION    = 8'h1C;
  localparam logic [7:0] OFF_PORT_F_ANALOG       = 8'h20;
  localparam logic [7:0] OFF_PERIPH_CONTROL      = 8'h24;

  localparam int PORT_E_PULLUP_BIT = 6;
  localparam int PORT_F_PULLUP_BIT = 5;
  localparam int CTRL_TX_ENABLE_BIT = 0;
  localparam int CTRL_SYNC_MODE_BIT = 1;
  localparam int CTRL_SYNC_MASTER_BIT = 2;
  localparam int CTRL_SYNC_DATA_OUT_BIT = 3;
  localparam int CTRL_CAN_ENABLE_BIT = 4;
  localparam int CTRL_MOD_OUT_ENABLE_BIT = 5;

  localparam int CAN_RX_BIT = 4;
  localparam int CAN_TX_BIT = 5;
  localparam int SER_DATA_BIT = 6;
  localparam int SER_CLOCK_BIT = 7;
  localparam int MOD_SRC_BIT = 0;
  localparam int MOD_CARRIER1_BIT = 2;
  localparam int MOD_CARRIER2_BIT = 4;
  localparam int MOD_OUT_BIT = 6;

  localparam logic [7:0] RST_LATCH     = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_PAD       = 8'h00;
  localparam logic [7:0] RST_ANALOG_E  = 8'h00;
  localparam logic [7:0] RST_ANALOG_F  = 8'hFE;
  localparam logic [7:0] RST_CONTROL   = 8'h00;
  localparam logic [3:0] PORT_E_HIGH_MASK = 4'hF;

  localparam int SYNC_STAGES = 2;
endpackage

// [rtl/gpio_port_ef.sv]
/*
  Pin logic for port F (8 bits) and port E bits 7:4 with peripheral
  overrides, behind an APB slave.
  Assumes pads resolve level from out/oe_n/pullup; peripherals on pclk.
*/
`timescale 1ns/1ps
// Operation
// [R01] Port F is eight bidirectional pins
// [R02] Each pin has its own direction bit
// [R03] Direction clear drives latch; set reads pin
// [R04] Pin inputs sampled as Schmitt digital inputs
// [R05] Pad configuration bit 5 enables port F pull-ups
// [R06] Output pins never get a pull-up
// [R07] Reset leaves all pull-ups disabled
// [R08] Reset makes port F 7:1 analog, read zero
// [R09] Port F pins 2,4 feed modulator carriers
// [R10] CAN on port E 4,5 when remap cleared
// [R11] Serial async transmit overrides port E 7 latch
// [R12] Serial sync data out overrides port E 6
// [R13] Software sets pin 6 input for sync receive
// [R14] Port E 7 carries sync clock, master drives
// [R15] Absent port E 7:4 pins read zero
// [R16] Pin write loads latch; reads return levels
module gpio_port_ef #(
  parameter int  PORT_WIDTH     = 8,
  parameter bit  HAS_PORT_E_HIGH = 1'b1,
  parameter bit  LARGE_PACKAGE  = 1'b1
) (
  // Clock, reset, enable
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        clk_en,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  // Port F pads
  input  wire logic [7:0]  port_f_pad_in,
  output logic      [7:0]  port_f_pad_out,
  output logic      [7:0]  port_f_pad_oe_n,
  output logic      [7:0]  port_f_pad_pullup,
  // Port E upper pads (bits 7:4 of the vector)
  input  wire logic [3:0]  port_e_pad_in,
  output logic      [3:0]  port_e_pad_out,
  output logic      [3:0]  port_e_pad_oe_n,
  output logic      [3:0]  port_e_pad_pullup,
  // Configuration strap
  input  wire logic        can_pin_remap_select,
  // CAN controller
  input  wire logic        can_transmit_pin,
  output logic             can_receive_pin,
  // Second serial port
  input  wire logic        serial2_async_transmit,
  input  wire logic        serial2_sync_data,
  input  wire logic        serial2_sync_clock,
  output logic             serial2_async_receive,
  output logic             serial2_sync_data_in,
  output logic             serial2_sync_clock_in,
  // Modulator
  input  wire logic        modulator_output,
  output logic             modulator_source_in,
  output logic             modulator_carrier_one,
  output logic             modulator_carrier_two
);
  initial begin
    if (PORT_WIDTH != 8)
      $error("gpio_port_ef supports only 8-bit ports");
  end

  // Registers
  logic [7:0] port_e_output_latch_r;
  logic [7:0] port_e_output_latch_nxt;
  logic [7:0] port_e_direction_r;
  logic [7:0] port_e_direction_nxt;
  logic [7:0] pad_configuration_r;
  logic [7:0] pad_configuration_nxt;
  logic [7:0] analog_select_low_r;
  logic [7:0] analog_select_low_nxt;
  logic [7:0] port_f_output_latch_r;
  logic [7:0] port_f_output_latch_nxt;
  logic [7:0] port_f_direction_r;
  logic [7:0] port_f_direction_nxt;
  logic [7:0] port_f_analog_r;
  logic [7:0] port_f_analog_nxt;
  logic [7:0] periph_control_r;
  logic [7:0] periph_control_nxt;
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic        remap_r;
  logic        remap_nxt;

  logic [11:0] pad_sync;
  logic [7:0]  f_sync;
  logic [7:0]  e_sync;
  logic [7:0]  f_levels;
  logic [7:0]  e_levels;
  logic        access;
  logic        wr_en;
  logic        addr_ok;
  logic [7:0]  wbyte;
  logic        can_on_e;
  logic [7:0]  e_drive_en;
  logic [7:0]  e_drive_val;
  logic [7:0]  f_drive_en;
  logic [7:0]  f_drive_val;
  logic        tx_en;
  logic        sync_mode;
  logic        sync_master;
  logic        sync_dout;

  // Pins are asynchronous; two flops before any read
  pin_sync #(
    .WIDTH (12)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .async_in ({port_e_pad_in, port_f_pad_in}),
    .sync_out (pad_sync)
  );

  // Schmitt buffering is in the pad; the core sees clean levels
  assign f_sync = pad_sync[7:0]; // see [R04]
  assign e_sync = {pad_sync[11:8], 4'h0};

  // APB: zero wait states, error on unmapped word
  assign access = psel & penable;
  assign pready = 1'b1;
  assign wr_en  = access & pwrite & pstrb[0] & clk_en;
  assign wbyte  = pwdata[7:0];

  always_comb begin
    unique case (paddr)
      gpio_ef_pkg::OFF_PORT_E_PIN_LEVELS,
      gpio_ef_pkg::OFF_PORT_E_OUTPUT_LATCH,
      gpio_ef_pkg::OFF_PORT_E_DIRECTION,
      gpio_ef_pkg::OFF_PAD_CONFIGURATION,
      gpio_ef_pkg::OFF_ANALOG_SELECT_LOW,
      gpio_ef_pkg::OFF_PORT_F_PIN_LEVELS,
      gpio_ef_pkg::OFF_PORT_F_OUTPUT_LATCH,
      gpio_ef_pkg::OFF_PORT_F_DIRECTION,
      gpio_ef_pkg::OFF_PORT_F_ANALOG,
      gpio_ef_pkg::OFF_PERIPH_CONTROL: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = access & ~addr_ok;

  // Analog pins and absent pins read zero
  always_comb begin
    f_levels = f_sync & ~port_f_analog_r; // see [R08]
    e_levels = e_sync & ~analog_select_low_r;
    if (!HAS_PORT_E_HIGH) begin
      e_levels = 8'h00; // see [R15]
    end
  end

  // Register next values
  always_comb begin
    port_e_output_latch_nxt = port_e_output_latch_r;
    port_e_direction_nxt    = port_e_direction_r;
    pad_configuration_nxt   = pad_configuration_r;
    analog_select_low_nxt   = analog_select_low_r;
    port_f_output_latch_nxt = port_f_output_latch_r;
    port_f_direction_nxt    = port_f_direction_r;
    port_f_analog_nxt       = port_f_analog_r;
    periph_control_nxt      = periph_control_r;
    if (wr_en) begin
      unique case (paddr)
        // Writing the pin register loads the latch; see [R16]
        gpio_ef_pkg::OFF_PORT_E_PIN_LEVELS,
        gpio_ef_pkg::OFF_PORT_E_OUTPUT_LATCH:
          port_e_output_latch_nxt = {wbyte[7:4], 4'h0};
        gpio_ef_pkg::OFF_PORT_E_DIRECTION:
          port_e_direction_nxt = {wbyte[7:4], 4'h0};
        gpio_ef_pkg::OFF_PAD_CONFIGURATION:
          pad_configuration_nxt = wbyte;
        gpio_ef_pkg::OFF_ANALOG_SELECT_LOW:
          analog_select_low_nxt = wbyte;
        gpio_ef_pkg::OFF_PORT_F_PIN_LEVELS,
        gpio_ef_pkg::OFF_PORT_F_OUTPUT_LATCH:
          port_f_output_latch_nxt = wbyte; // see [R16]
        gpio_ef_pkg::OFF_PORT_F_DIRECTION:
          port_f_direction_nxt = wbyte; // see [R02]
        gpio_ef_pkg::OFF_PORT_F_ANALOG:
          port_f_analog_nxt = wbyte;
        gpio_ef_pkg::OFF_PERIPH_CONTROL:
          periph_control_nxt = wbyte;
        default: ;
      endcase
    end
  end

  // Read data, registered so prdata comes from flops
  always_comb begin
    prdata_nxt = prdata_r;
    if (psel & ~penable & ~pwrite & clk_en) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        gpio_ef_pkg::OFF_PORT_E_PIN_LEVELS:
          prdata_nxt[7:0] = e_levels; // see [R16]
        gpio_ef_pkg::OFF_PORT_E_OUTPUT_LATCH:
          prdata_nxt[7:0] = port_e_output_latch_r;
        gpio_ef_pkg::OFF_PORT_E_DIRECTION:
          prdata_nxt[7:0] = port_e_direction_r;
        gpio_ef_pkg::OFF_PAD_CONFIGURATION:
          prdata_nxt[7:0] = pad_configuration_r;
        gpio_ef_pkg::OFF_ANALOG_SELECT_LOW:
          prdata_nxt[7:0] = analog_select_low_r;
        gpio_ef_pkg::OFF_PORT_F_PIN_LEVELS:
          prdata_nxt[7:0] = f_levels; // see [R16]
        gpio_ef_pkg::OFF_PORT_F_OUTPUT_LATCH:
          prdata_nxt[7:0] = port_f_output_latch_r;
        gpio_ef_pkg::OFF_PORT_F_DIRECTION:
          prdata_nxt[7:0] = port_f_direction_r;
        gpio_ef_pkg::OFF_PORT_F_ANALOG:
          prdata_nxt[7:0] = port_f_analog_r;
        gpio_ef_pkg::OFF_PERIPH_CONTROL:
          prdata_nxt[7:0] = periph_control_r;
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
  end
  assign prdata = prdata_r;

  // The remap strap is caught after reset release, never by the reset
  assign remap_nxt = clk_en ? can_pin_remap_select : remap_r;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_e_output_latch_r <= gpio_ef_pkg::RST_LATCH;
      port_e_direction_r    <= gpio_ef_pkg::RST_DIRECTION;
      pad_configuration_r   <= gpio_ef_pkg::RST_PAD; // see [R07]
      analog_select_low_r   <= gpio_ef_pkg::RST_ANALOG_E;
      port_f_output_latch_r <= gpio_ef_pkg::RST_LATCH;
      port_f_direction_r    <= gpio_ef_pkg::RST_DIRECTION;
      port_f_analog_r       <= gpio_ef_pkg::RST_ANALOG_F; // see [R08]
      periph_control_r      <= gpio_ef_pkg::RST_CONTROL;
      prdata_r              <= 32'h0000_0000;
      remap_r               <= 1'b1;
    end else begin
      port_e_output_latch_r <= port_e_output_latch_nxt;
      port_e_direction_r    <= port_e_direction_nxt;
      pad_configuration_r   <= pad_configuration_nxt;
      analog_select_low_r   <= analog_select_low_nxt;
      port_f_output_latch_r <= port_f_output_latch_nxt;
      port_f_direction_r    <= port_f_direction_nxt;
      port_f_analog_r       <= port_f_analog_nxt;
      periph_control_r      <= periph_control_nxt;
      prdata_r              <= prdata_nxt;
      remap_r               <= remap_nxt;
    end
  end

  // Peripheral controls
  assign tx_en       = periph_control_r[gpio_ef_pkg::CTRL_TX_ENABLE_BIT];
  assign sync_mode   = periph_control_r[gpio_ef_pkg::CTRL_SYNC_MODE_BIT];
  assign sync_master = periph_control_r[gpio_ef_pkg::CTRL_SYNC_MASTER_BIT];
  assign sync_dout   = periph_control_r[gpio_ef_pkg::CTRL_SYNC_DATA_OUT_BIT];
  assign can_on_e    = LARGE_PACKAGE & ~remap_r
                     & periph_control_r[gpio_ef_pkg::CTRL_CAN_ENABLE_BIT];

  // Port E drive: direction, then peripheral overrides
  always_comb begin
    e_drive_en  = ~port_e_direction_r; // see [R03]
    e_drive_val = port_e_output_latch_r;
    if (can_on_e) begin
      e_drive_en[gpio_ef_pkg::CAN_TX_BIT]  = 1'b1; // see [R10]
      e_drive_val[gpio_ef_pkg::CAN_TX_BIT] = can_transmit_pin;
      e_drive_en[gpio_ef_pkg::CAN_RX_BIT]  = 1'b0;
    end
    if (tx_en && sync_mode && sync_dout) begin
      e_drive_en[gpio_ef_pkg::SER_DATA_BIT]  = 1'b1; // see [R12]
      e_drive_val[gpio_ef_pkg::SER_DATA_BIT] = serial2_sync_data;
    end
    if (tx_en && !sync_mode) begin
      e_drive_en[gpio_ef_pkg::SER_CLOCK_BIT]  = 1'b1; // see [R11]
      e_drive_val[gpio_ef_pkg::SER_CLOCK_BIT] = serial2_async_transmit;
    end else if (sync_mode && sync_master) begin
      e_drive_en[gpio_ef_pkg::SER_CLOCK_BIT]  = 1'b1; // see [R14]
      e_drive_val[gpio_ef_pkg::SER_CLOCK_BIT] = serial2_sync_clock;
    end
    if (!HAS_PORT_E_HIGH) begin
      e_drive_en = 8'h00;
    end
  end

  // Port F drive: latch, or modulator output on pin 6
  always_comb begin
    f_drive_en  = ~port_f_direction_r; // see [R01] [R03]
    f_drive_val = port_f_output_latch_r;
    if (periph_control_r[gpio_ef_pkg::CTRL_MOD_OUT_ENABLE_BIT]) begin
      f_drive_val[gpio_ef_pkg::MOD_OUT_BIT] = modulator_output;
    end
  end

  // Pull-ups: one enable per port (bit 5 for F, bit 6 for E), dropped on any driving pin
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_f_pad
      assign port_f_pad_out[gi]    = f_drive_val[gi];
      assign port_f_pad_oe_n[gi]   = ~f_drive_en[gi];
      assign port_f_pad_pullup[gi] = pad_configuration_r[
        gpio_ef_pkg::PORT_F_PULLUP_BIT] & ~f_drive_en[gi]; // see [R05] [R06]
    end
    for (gi = 0; gi < 4; gi++) begin : g_e_pad
      assign port_e_pad_out[gi]    = e_drive_val[gi + 4];
      assign port_e_pad_oe_n[gi]   = ~e_drive_en[gi + 4];
      assign port_e_pad_pullup[gi] = pad_configuration_r[
        gpio_ef_pkg::PORT_E_PULLUP_BIT] & ~e_drive_en[gi + 4]; // see [R06]
    end
  endgenerate

  // Peripheral inputs; receive pin 6 relies on software setting input
  assign can_receive_pin       = can_on_e & e_sync[gpio_ef_pkg::CAN_RX_BIT];
  assign serial2_async_receive = e_sync[gpio_ef_pkg::SER_DATA_BIT];
  assign serial2_sync_data_in  = e_sync[gpio_ef_pkg::SER_DATA_BIT]
                               & port_e_direction_r[gpio_ef_pkg::SER_DATA_BIT];
  // see [R13]
  assign serial2_sync_clock_in = e_sync[gpio_ef_pkg::SER_CLOCK_BIT]
                               & port_e_direction_r[gpio_ef_pkg::SER_CLOCK_BIT];
  // see [R14]
  assign modulator_source_in   = f_sync[gpio_ef_pkg::MOD_SRC_BIT]
                               & port_f_direction_r[gpio_ef_pkg::MOD_SRC_BIT];
  assign modulator_carrier_one = f_sync[gpio_ef_pkg::MOD_CARRIER1_BIT]
                          & port_f_direction_r[gpio_ef_pkg::MOD_CARRIER1_BIT];
  // see [R09]
  assign modulator_carrier_two = f_sync[gpio_ef_pkg::MOD_CARRIER2_BIT]
                          & port_f_direction_r[gpio_ef_pkg::MOD_CARRIER2_BIT];
endmodule

// [rtl/pin_sync.sv]
/*
  Two-flop synchroniser for a vector of pin levels.
  Assumes asynchronous pins and a clock enable shared with the port logic.
*/
`timescale 1ns/1ps
module pin_sync #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             clk_en,
  // Data
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = clk_en ? async_in : meta_r;
    sync_nxt = clk_en ? meta_r : sync_r;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_out = sync_r;
endmodule

// [tb/gpio_ef_monitor.sv]
/*
  Checker for the port E/F pin logic, bound into gpio_port_ef.
  Assumes writes land at the access edge and pad outputs are combinational.
*/
`timescale 1ns/1ps
module gpio_ef_monitor (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        clk_en,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  // Pads
  input wire logic [7:0]  port_f_pad_in,
  input wire logic [7:0]  port_f_pad_out,
  input wire logic [7:0]  port_f_pad_oe_n,
  input wire logic [7:0]  port_f_pad_pullup,
  input wire logic [3:0]  port_e_pad_out,
  input wire logic [3:0]  port_e_pad_oe_n,
  input wire logic [3:0]  port_e_pad_pullup,
  // Peripherals
  input wire logic        serial2_async_transmit,
  input wire logic        serial2_sync_data,
  input wire logic        serial2_sync_clock,
  input wire logic        modulator_carrier_one
);
  logic       wr_go;
  logic [7:0] ctrl_r;
  logic [7:0] ctrl_nxt;
  logic [7:0] ana_r;
  logic [7:0] ana_nxt;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  assign wr_go = psel && penable && pwrite && pstrb[0] && clk_en;
  // Shadow copies, so overrides are judged on the settings that rule them
  always_comb begin
    ctrl_nxt = ctrl_r;
    ana_nxt  = ana_r;
    if (wr_go && paddr == gpio_ef_pkg::OFF_PERIPH_CONTROL)
      ctrl_nxt = pwdata[7:0];
    if (wr_go && paddr == gpio_ef_pkg::OFF_PORT_F_ANALOG)
      ana_nxt = pwdata[7:0];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r <= gpio_ef_pkg::RST_CONTROL;
      ana_r  <= gpio_ef_pkg::RST_ANALOG_F;
    end else begin
      ctrl_r <= ctrl_nxt;
      ana_r  <= ana_nxt;
    end
  end
  // Bit 6 is left out of the port F checks except at reset: the modulator may own it
  property p_rst_pull;
    $rose(presetn) |-> port_f_pad_pullup == 8'h00 && port_e_pad_pullup == 4'h0;
  endproperty
  a_rst_pull: assert property (p_rst_pull) else $error("pull-up on at reset");
  property p_pull_cfg;
    wr_go && paddr == gpio_ef_pkg::OFF_PAD_CONFIGURATION |=>
      (port_f_pad_pullup & 8'hBF) ==
      (port_f_pad_oe_n & 8'hBF & {8{$past(pwdata[5])}});
  endproperty
  a_pull_cfg: assert property (p_pull_cfg) else $error("pull-up enable wrong");
  property p_pull_out;
    (port_f_pad_pullup & ~port_f_pad_oe_n & 8'hBF) == 8'h00;
  endproperty
  a_pull_out: assert property (p_pull_out) else $error("pull-up on output");
  property p_latch;
    wr_go && paddr == gpio_ef_pkg::OFF_PORT_F_OUTPUT_LATCH |=>
      ((port_f_pad_out ^ $past(pwdata[7:0])) & ~port_f_pad_oe_n & 8'hBF) == 8'h00;
  endproperty
  a_latch: assert property (p_latch) else $error("pin not from latch");
  property p_dir;
    wr_go && paddr == gpio_ef_pkg::OFF_PORT_F_DIRECTION |=>
      (port_f_pad_oe_n & 8'hBF) == ($past(pwdata[7:0]) & 8'hBF);
  endproperty
  a_dir: assert property (p_dir) else $error("direction not per pin");
  property p_carrier;
    (clk_en && port_f_pad_oe_n[2] && !ana_r[2] && $stable(port_f_pad_in[2]))[*3]
      |-> modulator_carrier_one == port_f_pad_in[2];
  endproperty
  a_carrier: assert property (p_carrier) else $error("carrier one wrong");
  property p_async;
    ctrl_r[0] && !ctrl_r[1] |->
      !port_e_pad_oe_n[3] && port_e_pad_out[3] == serial2_async_transmit;
  endproperty
  a_async: assert property (p_async) else $error("async out lost");
  property p_sdata;
    ctrl_r[0] && ctrl_r[1] && ctrl_r[3] |->
      !port_e_pad_oe_n[2] && port_e_pad_out[2] == serial2_sync_data;
  endproperty
  a_sdata: assert property (p_sdata) else $error("sync data lost");
  property p_sclk;
    ctrl_r[0] && ctrl_r[1] && ctrl_r[2] |->
      !port_e_pad_oe_n[3] && port_e_pad_out[3] == serial2_sync_clock;
  endproperty
  a_sclk: assert property (p_sclk) else $error("sync clock lost");
endmodule
bind gpio_port_ef gpio_ef_monitor i_mon (.*);

// [tb/pad_board_model.sv]
/*
  Board side of one port: resolves each pad level.
  Assumes the device drive wins; a floating pad wobbles every cycle.
*/
`timescale 1ns/1ps
module pad_board_model #(
  parameter int W = 8
) (
  // Clock
  input  wire logic         pclk,
  // Device side
  input  wire logic [W-1:0] pad_out,
  input  wire logic [W-1:0] oe_n,
  input  wire logic [W-1:0] pu_en,
  // Board drive
  input  wire logic         ext_en,
  input  wire logic [W-1:0] ext_val,
  output logic      [W-1:0] pad_in
);
  logic flt_r = 1'b0;
  always @(posedge pclk) begin
    flt_r <= ~flt_r;
  end
  // Loose pads must not read as a steady level
  always_comb begin
    for (int i = 0; i < W; i++) begin
      if (!oe_n[i])
        pad_in[i] = pad_out[i];
      else if (ext_en)
        pad_in[i] = ext_val[i];
      else if (pu_en[i])
        pad_in[i] = 1'b1;
      else
        pad_in[i] = flt_r;
    end
  end
endmodule

// [tb/tb_gpio_port_e_f_pin_logic.sv]
/*
  Testbench for gpio_port_ef: APB master, board models, scenarios.
  Assumes zero-wait APB and two-flop pin synchronisers.
*/
`timescale 1ns/1ps
module tb_gpio_port_e_f_pin_logic;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr, f_in, f_out, f_oen, f_pu, f_ext;
  logic [31:0] pwdata, prdata, r;
  logic [3:0]  e_in, e_out, e_oen, e_pu, e_ext;
  logic        f_en, e_en, can_tx, tx_a, sd, sc, can_rx, rx_a, sd_in, sc_in;
  logic        msrc, mc1, mc2, err, ce, mo;
  int          bad_count, cmp_count;
  always #50 pclk = ~pclk;
  gpio_port_ef i_dut (.pclk(pclk), .presetn(presetn), .clk_en(ce),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(4'h1), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .port_f_pad_in(f_in), .port_f_pad_out(f_out),
    .port_f_pad_oe_n(f_oen), .port_f_pad_pullup(f_pu),
    .port_e_pad_in(e_in), .port_e_pad_out(e_out), .port_e_pad_oe_n(e_oen),
    .port_e_pad_pullup(e_pu), .can_pin_remap_select(1'b0),
    .can_transmit_pin(can_tx), .can_receive_pin(can_rx),
    .serial2_async_transmit(tx_a), .serial2_sync_data(sd),
    .serial2_sync_clock(sc), .serial2_async_receive(rx_a),
    .serial2_sync_data_in(sd_in), .serial2_sync_clock_in(sc_in),
    .modulator_output(mo), .modulator_source_in(msrc),
    .modulator_carrier_one(mc1), .modulator_carrier_two(mc2));
  pad_board_model #(.W(8)) i_brd_f (.pclk(pclk), .pad_out(f_out),
    .oe_n(f_oen), .pu_en(f_pu), .ext_en(f_en), .ext_val(f_ext),
    .pad_in(f_in));
  pad_board_model #(.W(4)) i_brd_e (.pclk(pclk), .pad_out(e_out),
    .oe_n(e_oen), .pu_en(e_pu), .ext_en(e_en), .ext_val(e_ext),
    .pad_in(e_in));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("compares=%0d mismatches=%0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // One transfer; the wait is bounded so a stuck slave ends the run
  task automatic apb(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      close_out();
    end
    r = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic t_reset;
    apb(gpio_ef_pkg::OFF_PORT_F_DIRECTION, 1'b0, 8'h00);
    chk(r, 32'h000000FF);
    apb(gpio_ef_pkg::OFF_PORT_F_PIN_LEVELS, 1'b0, 8'h00);
    chk(r, 32'h00000001);
    chk({f_pu, e_pu, f_oen}, 20'h000FF);
    $display("test reset done");
  endtask
  task automatic t_port_f;
    apb(gpio_ef_pkg::OFF_PORT_F_ANALOG, 1'b1, 8'h00);
    apb(gpio_ef_pkg::OFF_PORT_F_DIRECTION, 1'b1, 8'hA5);
    apb(gpio_ef_pkg::OFF_PORT_F_OUTPUT_LATCH, 1'b1, 8'h3C);
    f_ext <= 8'h96;
    repeat (3) @(posedge pclk);
    chk({f_oen, f_out & 8'h5A}, {8'hA5, 8'h18});
    apb(gpio_ef_pkg::OFF_PERIPH_CONTROL, 1'b1, 8'h20);
    mo <= 1'b1;
    @(posedge pclk);
    chk(f_out[6], 1'b1);
    mo <= 1'b0;
    apb(gpio_ef_pkg::OFF_PERIPH_CONTROL, 1'b1, 8'h00);
    apb(gpio_ef_pkg::OFF_PORT_F_PIN_LEVELS, 1'b0, 8'h00);
    chk(r, 32'h0000009C);
    apb(gpio_ef_pkg::OFF_PORT_F_PIN_LEVELS, 1'b1, 8'hC3);
    apb(gpio_ef_pkg::OFF_PORT_F_OUTPUT_LATCH, 1'b0, 8'h00);
    chk(r, 32'h000000C3);
    $display("test port f done");
  endtask
  task automatic t_pullup;
    f_en <= 1'b0;
    apb(gpio_ef_pkg::OFF_PAD_CONFIGURATION, 1'b1, 8'h60);
    repeat (3) @(posedge pclk);
    chk({f_pu, e_pu}, {8'hA5, 4'hF});
    apb(gpio_ef_pkg::OFF_PORT_F_PIN_LEVELS, 1'b0, 8'h00);
    chk(r, 32'h000000E7);
    apb(gpio_ef_pkg::OFF_PAD_CONFIGURATION, 1'b1, 8'h40);
    @(posedge pclk);
    chk({f_pu, e_pu}, {8'h00, 4'hF});
    f_en <= 1'b1;
    $display("test pull-up done");
  endtask
  task automatic t_periph;
    logic [7:0] ctl[4] = '{8'h01, 8'h0B, 8'h07, 8'h10};
    int         pin[4] = '{3, 2, 3, 1};
    apb(gpio_ef_pkg::OFF_PORT_E_DIRECTION, 1'b1, 8'h00);
    for (int i = 0; i < 4; i++) begin
      for (int v = 0; v < 2; v++) begin
        {tx_a, sd, sc, can_tx} <= {4{v[0]}};
        apb(gpio_ef_pkg::OFF_PORT_E_OUTPUT_LATCH, 1'b1, v[0] ? 8'h00 : 8'hF0);
        apb(gpio_ef_pkg::OFF_PERIPH_CONTROL, 1'b1, ctl[i]);
        @(posedge pclk);
        chk({e_oen[pin[i]], e_out[pin[i]]}, {1'b0, v[0]});
      end
    end
    apb(gpio_ef_pkg::OFF_PERIPH_CONTROL, 1'b1, 8'h00);
    $display("test peripheral out done");
  endtask
  task automatic t_inputs;
    apb(gpio_ef_pkg::OFF_PORT_F_DIRECTION, 1'b1, 8'hFF);
    apb(gpio_ef_pkg::OFF_PORT_E_DIRECTION, 1'b1, 8'hF0);
    apb(gpio_ef_pkg::OFF_PERIPH_CONTROL, 1'b1, 8'h02);
    for (int v = 1; v >= 0; v--) begin
      f_ext <= v[0] ? 8'h14 : 8'h00;
      e_ext <= v[0] ? 4'hC : 4'h0;
      repeat (3) @(posedge pclk);
      chk({mc1, mc2}, {2{v[0]}});
      chk({sd_in, sc_in, rx_a}, {3{v[0]}});
    end
    $display("test peripheral in done");
  endtask
  task automatic t_unmapped;
    apb(8'h28, 1'b1, 8'h5A);
    chk({31'h0, err}, 32'h00000001);
    apb(8'h28, 1'b0, 8'h00);
    chk({err, r}, {1'b1, 32'h0});
    // Write while frozen must be lost
    ce <= 1'b0;
    apb(gpio_ef_pkg::OFF_PORT_F_OUTPUT_LATCH, 1'b1, 8'h00);
    ce <= 1'b1;
    apb(gpio_ef_pkg::OFF_PORT_F_OUTPUT_LATCH, 1'b0, 8'h00);
    chk(r, 32'h000000C3);
    $display("test unmapped done");
  endtask
  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {can_tx, tx_a, sd, sc, e_ext, e_en} = '0;
    {ce, mo} = 2'b10;
    {f_en, f_ext} = {1'b1, 8'hFF};
    bad_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    t_reset();
    t_port_f();
    t_pullup();
    t_periph();
    e_en <= 1'b1;
    t_inputs();
    t_unmapped();
    close_out();
  end
endmodule
